// file: logic/sms_pkg.sv
package sms_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_NS = 50;
  localparam int SCK_HALF_NS = 200;
  // Least half period, rounded up to whole clocks
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + MCLK_NS - 1) / MCLK_NS;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int DIV_W = 8;
  localparam int ERR_W = 6;

  // ----------------------------------------
  // Error flag positions
  // ----------------------------------------
  localparam int ERR_MODF = 0;
  localparam int ERR_RDOVF = 1;
  localparam int ERR_OVR = 2;
  localparam int ERR_PAR = 3;
  localparam int ERR_FRM = 4;
  localparam int ERR_UDR = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_SCK = 1'h0;
  localparam logic [ERR_W-1:0] RST_ERR = 6'h00;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    SMS_W8 = 2'h0,
    SMS_W16 = 2'h1,
    SMS_W32 = 2'h2
  } sms_width_t;

  typedef enum logic [1:0] {
    SMS_IDLE = 2'h0,
    SMS_LOAD = 2'h1,
    SMS_RUN = 2'h2,
    SMS_TAIL = 2'h3
  } sms_state_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [6:0] sms_unit_bits(input logic [1:0] w);
    logic [6:0] b;
    b = 7'h08;
    unique case (w)
      SMS_W16: b = 7'h10;
      SMS_W32: b = 7'h20;
      default: b = 7'h08;
    endcase
    return b;
  endfunction

  // Gap between the unit's bits and the word edge they shift from
  function automatic logic [5:0] sms_pad(input logic [1:0] w);
    logic [6:0] d;
    d = 7'h20 - sms_unit_bits(w);
    return d[5:0];
  endfunction

endpackage

// file: logic/sms_sync.sv
`timescale 1ns/1ps

module sms_sync #(
  parameter int W = 3
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sms_sync_t;

  sms_sync_t r_ff;
  sms_sync_t nxt_r;

  // First stage feeds only the second; edges come from later stages
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = din;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign dout = r_ff.s2;
  assign rise = r_ff.s2 & ~r_ff.s3;
  assign fall = ~r_ff.s2 & r_ff.s3;

endmodule // sms_sync

// file: logic/sms_channel.sv
`timescale 1ns/1ps

module sms_channel #(
  parameter int HALF_CYC = sms_pkg::SCK_HALF_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic power_en,
  input wire logic master_en,
  input wire logic cpha,
  input wire logic cpol,
  input wire logic lsb_first,
  input wire logic [1:0] width_sel,
  input wire logic modf_en,
  input wire logic tx_en,
  input wire logic rx_en,
  input wire logic tx_dma_en,
  input wire logic rx_dma_en,
  input wire logic start,
  input wire logic abort,
  input wire logic [sms_pkg::CNT_W-1:0] unit_count,
  input wire logic [sms_pkg::DATA_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [sms_pkg::DATA_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ack,
  input wire logic [sms_pkg::ERR_W-1:0] err_clr,
  output logic [sms_pkg::ERR_W-1:0] err_flags,
  output logic busy,
  output logic irq_rx,
  output logic irq_tx,
  output logic irq_done,
  output logic irq_err,
  output logic evt_abort,
  output logic dma_rx_req,
  output logic dma_tx_req,
  input wire logic sck_pad,
  output logic sck_drv,
  output logic sck_en,
  input wire logic sdi_pad,
  output logic sdo_drv,
  output logic sdo_en,
  input wire logic slave_select_line_a_n_pad,
  output logic slave_select_line_a_n_drv,
  output logic slave_select_line_a_n_en
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sms_pkg::sms_state_t st;
    logic [sms_pkg::DIV_W-1:0] div;
    logic sck;
    logic [6:0] ecnt;
    logic [sms_pkg::CNT_W-1:0] left;
    logic [sms_pkg::DATA_W-1:0] txsh;
    logic [sms_pkg::DATA_W-1:0] rxsh;
    logic sdo;
    logic ss_drv;
    logic [sms_pkg::DATA_W-1:0] txh;
    logic txf;
    logic [sms_pkg::DATA_W-1:0] rxd;
    logic rxf;
    logic done;
    logic abrt;
    logic [sms_pkg::ERR_W-1:0] err;
    logic mst;
    logic pha;
    logic lsb;
    logic [1:0] wid;
    logic txe;
    logic rxe;
    // Own select drive delayed by the pad synchroniser depth
    logic [1:0] ss_hold;
  } sms_core_t;

  sms_core_t r_ff;
  sms_core_t nxt_r;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  sms_sync #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din({slave_select_line_a_n_pad, sdi_pad, sck_pad}),
    .dout(pin_s),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  logic sdi_s;
  logic ss_n_s;
  assign sdi_s = pin_s[1];
  assign ss_n_s = pin_s[2];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  localparam logic [sms_pkg::DIV_W-1:0] HALF_LAST = sms_pkg::DIV_W'(HALF_CYC - 1);

  logic ev;
  logic samp;
  logic load;
  logic last_edge;
  logic [6:0] bits;
  logic [5:0] pad;
  logic [sms_pkg::DATA_W-1:0] word;
  logic [sms_pkg::DATA_W-1:0] got;

  always_comb begin
    nxt_r = r_ff;
    ev = 1'b0;
    samp = 1'b0;
    load = 1'b0;
    last_edge = 1'b0;
    bits = sms_pkg::sms_unit_bits(r_ff.wid);
    pad = sms_pkg::sms_pad(r_ff.wid);
    word = '0;
    got = '0;
    nxt_r.done = 1'b0;
    nxt_r.abrt = 1'b0;
    // Clear first so that a new event in the same cycle survives
    nxt_r.err = r_ff.err & ~err_clr;
    // The synced pad lags our own release by two clocks
    nxt_r.ss_hold = {r_ff.ss_hold[0], r_ff.ss_drv};

    if (tx_valid && !r_ff.txf) begin
      nxt_r.txf = 1'b1;
      nxt_r.txh = tx_data;
    end
    if (rx_ack) begin
      if (r_ff.rxf) begin
        nxt_r.rxf = 1'b0;
      end else begin
        nxt_r.err[sms_pkg::ERR_RDOVF] = 1'b1;
      end
    end

    // Edge source: own divider as master, far clock as slave
    if (r_ff.st == sms_pkg::SMS_RUN || r_ff.st == sms_pkg::SMS_TAIL) begin
      if (r_ff.mst) begin
        if (r_ff.div == HALF_LAST) begin
          nxt_r.div = '0;
          if (r_ff.st == sms_pkg::SMS_RUN) begin
            nxt_r.sck = ~r_ff.sck;
            ev = 1'b1;
          end
        end else begin
          nxt_r.div = r_ff.div + 1'b1;
        end
      end else begin
        ev = (pin_rise[0] | pin_fall[0]) & ~ss_n_s;
      end
    end

    if (r_ff.st == sms_pkg::SMS_RUN && ev) begin
      // Edge number is ecnt+1, so an even ecnt means an odd edge
      samp = r_ff.pha ? r_ff.ecnt[0] : ~r_ff.ecnt[0];
      nxt_r.ecnt = r_ff.ecnt + 1'b1;
      last_edge = (r_ff.ecnt == ((bits << 1) - 7'h01));
      if (samp) begin
        nxt_r.rxsh = r_ff.lsb ? {sdi_s, r_ff.rxsh[31:1]} : {r_ff.rxsh[30:0], sdi_s};
      end else begin
        nxt_r.sdo = r_ff.lsb ? r_ff.txsh[0] : r_ff.txsh[31];
        nxt_r.txsh = r_ff.lsb ? (r_ff.txsh >> 1) : (r_ff.txsh << 1);
      end
    end

    if (last_edge) begin
      got = r_ff.lsb ? (nxt_r.rxsh >> pad) : nxt_r.rxsh;
      if (r_ff.rxe) begin
        if (nxt_r.rxf) begin
          nxt_r.err[sms_pkg::ERR_OVR] = 1'b1;
        end
        nxt_r.rxd = got;
        nxt_r.rxf = 1'b1;
      end
      nxt_r.left = r_ff.left - 1'b1;
      if (r_ff.left == sms_pkg::CNT_W'(1)) begin
        nxt_r.done = 1'b1;
        nxt_r.st = r_ff.mst ? sms_pkg::SMS_TAIL : sms_pkg::SMS_IDLE;
        nxt_r.div = '0;
      end else if (r_ff.mst) begin
        nxt_r.st = sms_pkg::SMS_LOAD;
      end else begin
        load = 1'b1;
      end
    end

    // Master waits for data; the slave cannot and sends zeros instead
    if (r_ff.st == sms_pkg::SMS_LOAD && (!r_ff.txe || r_ff.txf)) begin
      load = 1'b1;
    end

    if (r_ff.st == sms_pkg::SMS_TAIL && r_ff.div == HALF_LAST) begin
      nxt_r.st = sms_pkg::SMS_IDLE;
      nxt_r.ss_drv = 1'b0;
    end

    if (r_ff.st == sms_pkg::SMS_IDLE) begin
      nxt_r.sck = cpol;
      if (start && unit_count != '0) begin
        nxt_r.mst = master_en;
        nxt_r.pha = cpha;
        nxt_r.lsb = lsb_first;
        nxt_r.wid = width_sel;
        nxt_r.txe = tx_en;
        nxt_r.rxe = rx_en;
        nxt_r.left = unit_count;
        nxt_r.rxsh = '0;
        if (master_en) begin
          nxt_r.st = sms_pkg::SMS_LOAD;
        end else begin
          load = 1'b1;
        end
      end
    end

    if (load) begin
      bits = sms_pkg::sms_unit_bits(nxt_r.wid);
      pad = sms_pkg::sms_pad(nxt_r.wid);
      if (nxt_r.txe) begin
        if (r_ff.txf) begin
          word = r_ff.txh;
          nxt_r.txf = 1'b0;
        end else begin
          nxt_r.err[sms_pkg::ERR_UDR] = 1'b1;
        end
      end
      // MSB-first units sit left-justified so bit 31 always leads
      nxt_r.txsh = nxt_r.lsb ? word : (word << pad);
      nxt_r.ecnt = '0;
      nxt_r.div = '0;
      nxt_r.st = sms_pkg::SMS_RUN;
      nxt_r.ss_drv = nxt_r.mst;
      if (!nxt_r.pha) begin
        nxt_r.sdo = nxt_r.lsb ? nxt_r.txsh[0] : nxt_r.txsh[31];
        nxt_r.txsh = nxt_r.lsb ? (nxt_r.txsh >> 1) : (nxt_r.txsh << 1);
      end
    end

    // Slave: a select edge restarts bit framing
    if (!r_ff.mst && r_ff.st == sms_pkg::SMS_RUN) begin
      if (pin_rise[2] && r_ff.ecnt != '0 && modf_en) begin
        nxt_r.err[sms_pkg::ERR_MODF] = 1'b1;
      end
      if (pin_rise[2] || pin_fall[2]) begin
        nxt_r.ecnt = '0;
      end
    end

    // Master: someone else pulls select low while we are not driving it
    // Held off until our own release has passed the synchroniser,
    // otherwise every transfer end would look like a foreign driver
    if (master_en && modf_en && !r_ff.ss_drv && r_ff.ss_hold == 2'h0 && !ss_n_s) begin
      nxt_r.err[sms_pkg::ERR_MODF] = 1'b1;
      if (r_ff.st != sms_pkg::SMS_IDLE) begin
        nxt_r.st = sms_pkg::SMS_IDLE;
        nxt_r.abrt = 1'b1;
      end
    end

    if (abort && r_ff.st != sms_pkg::SMS_IDLE) begin
      nxt_r.st = sms_pkg::SMS_IDLE;
      nxt_r.abrt = 1'b1;
      nxt_r.done = 1'b0;
      nxt_r.ss_drv = 1'b0;
    end

    // Closing drops all state but the clock level, which goes to polarity, requests included
    if (!power_en) begin
      nxt_r = '0;
      nxt_r.sck = cpol;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic tx_want;
  assign tx_want = (r_ff.st != sms_pkg::SMS_IDLE) & r_ff.txe & ~r_ff.txf;

  assign tx_ready = ~r_ff.txf & power_en;
  assign rx_data = r_ff.rxd;
  assign rx_valid = r_ff.rxf;
  assign err_flags = r_ff.err;
  assign busy = r_ff.st != sms_pkg::SMS_IDLE;
  assign irq_rx = r_ff.rxf & ~rx_dma_en;
  assign dma_rx_req = r_ff.rxf & rx_dma_en;
  assign irq_tx = tx_want & ~tx_dma_en;
  assign dma_tx_req = tx_want & tx_dma_en;
  assign irq_done = r_ff.done;
  assign evt_abort = r_ff.abrt;
  // Parity and framing never arise in this framing and stay clear
  assign irq_err = |r_ff.err;

  // Clock pin is driven only by a powered master, so it rests at polarity
  assign sck_drv = r_ff.sck;
  assign sck_en = power_en & master_en;
  assign sdo_drv = r_ff.sdo;
  assign sdo_en = power_en & (master_en | (~ss_n_s & busy));
  // Select is released between transfers so a foreign driver can be seen
  assign slave_select_line_a_n_drv = 1'h0;
  assign slave_select_line_a_n_en = r_ff.ss_drv;

endmodule // sms_channel

// file: verification/sms_channel_monitor.sv
`timescale 1ns/1ps

module sms_channel_monitor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic power_en,
  input wire logic modf_en,
  input wire logic cpol,
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] unit_count,
  input wire logic busy,
  input wire logic irq_done,
  input wire logic evt_abort,
  input wire logic irq_err,
  input wire logic [5:0] err_flags,
  input wire logic rx_valid,
  input wire logic irq_rx,
  input wire logic dma_rx_req,
  input wire logic rx_dma_en,
  input wire logic sck_drv
);
  // Masks the $past look-back into the reset window
  logic [1:0] up_ff;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  end

  // ----
  // Checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  idle_clock_a: assert property (
    up_ff == 2'h3 && power_en && !busy && $past(!busy)
    && $past(power_en) && $stable(cpol) |-> sck_drv == cpol)
    else $error("serial clock off its idle level");
  start_busy_a: assert property (
    start && !busy && power_en && unit_count != 16'h0 |=> busy)
    else $error("start not taken");
  zero_count_a: assert property (
    start && !busy && unit_count == 16'h0 |=> !busy)
    else $error("empty transfer started");
  abort_event_a: assert property (
    abort && busy && power_en |=> evt_abort)
    else $error("abort not reported");
  done_pulse_a: assert property (
    irq_done |=> !irq_done)
    else $error("completion request too long");
  err_request_a: assert property (
    irq_err == (|err_flags))
    else $error("error request disagrees with flags");
  rx_request_a: assert property (
    rx_valid |-> irq_rx == !rx_dma_en && dma_rx_req == rx_dma_en)
    else $error("receive request misrouted");
  power_off_a: assert property (
    !power_en |=> !busy && !rx_valid && !irq_done && err_flags == 6'h00)
    else $error("closed channel still active");
  fault_off_a: assert property (
    !modf_en && !err_flags[0] ##1 !modf_en |-> !err_flags[0])
    else $error("mode fault while detection off");

  cover property (start && !busy && unit_count != 16'h0);
  cover property (evt_abort);
  cover property (irq_done);
endmodule // sms_channel_monitor

bind sms_channel sms_channel_monitor sms_channel_monitor_i (
  .mclk, .arst_n, .power_en, .modf_en, .cpol, .start, .abort, .unit_count, .busy,
  .irq_done, .evt_abort, .irq_err, .err_flags, .rx_valid, .irq_rx, .dma_rx_req,
  .rx_dma_en, .sck_drv
);

// file: verification/sms_spi_peer.sv
`timescale 1ns/1ps

module sms_spi_peer #(
  parameter logic [31:0] PAT = 32'hC3A5_96E1
) (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic cpha,
  input wire logic cpol,
  output logic miso,
  output logic [31:0] rx
);
  logic [31:0] sr = PAT;
  logic took = 1'b0;
  logic lastv = 1'b0;
  initial rx = 32'h0;
  always @(negedge ss_n) begin
    sr = PAT;
    took = 1'b0;
    rx = 32'h0;
  end
  always @(posedge ss_n) lastv = sr[31];
  // Shift only after a sample, so phase 1 keeps its first bit
  always @(sck) begin
    if (!ss_n) begin
      if (sck ^ cpol ^ cpha) begin
        rx = {rx[30:0], mosi};
        took = 1'b1;
      end else if (took) begin
        sr = {sr[30:0], 1'b0};
      end
    end
  end
  // Released line shows the inverse of the last bit
  assign miso = ss_n ? !lastv : sr[31];
endmodule // sms_spi_peer

// file: verification/test_sms_channel.sv
`timescale 1ns/1ps

module test_sms_channel;
  localparam logic [31:0] PAT = 32'hC3A5_96E1;
  typedef struct {logic [1:0] w; logic ph, pl, lf; logic [31:0] d;} sms_row_t;
  sms_row_t rows[4] = '{'{2'h0, 1'h0, 1'h0, 1'h0, 32'h3C}, '{2'h1, 1'h1, 1'h0, 1'h1, 32'hB00C},
    '{2'h2, 1'h0, 1'h1, 1'h0, 32'h1234_ABCD}, '{2'h0, 1'h1, 1'h1, 1'h1, 32'h81}};
  logic mclk, arst_n, power_en, master_en, cpha, cpol, lsb_first, modf_en, tx_dma_en;
  logic rx_dma_en, start, abort, tx_valid, rx_ack, ss_force, done_seen;
  logic [1:0] width_sel;
  logic [15:0] unit_count;
  logic [31:0] tx_data, rx_data, prx;
  logic [5:0] err_clr, err_flags;
  logic tx_ready, rx_valid, busy, irq_rx, irq_tx, irq_done, irq_err, evt_abort, dma_rx_req;
  logic dma_tx_req;
  logic sck_drv, sck_en, sdo_drv, ss_drv, ss_en, miso;
  int err_total, total_checks;
  wire sck = sck_en ? sck_drv : cpol;
  // Select is open drain with a pull-up
  wire ss_n = !((ss_en && !ss_drv) || ss_force);

  sms_channel sms_channel_i (.mclk, .arst_n, .power_en, .master_en, .cpha, .cpol,
    .lsb_first, .width_sel, .modf_en, .tx_en(1'b1), .rx_en(1'b1), .tx_dma_en, .rx_dma_en,
    .start, .abort, .unit_count, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ack, .err_clr, .err_flags, .busy, .irq_rx, .irq_tx, .irq_done, .irq_err, .evt_abort,
    .dma_rx_req, .dma_tx_req, .sck_pad(sck), .sck_drv, .sck_en, .sdi_pad(miso), .sdo_drv,
    .sdo_en(), .slave_select_line_a_n_pad(ss_n), .slave_select_line_a_n_drv(ss_drv),
    .slave_select_line_a_n_en(ss_en));
  sms_spi_peer #(.PAT(PAT)) sms_spi_peer_i (.sck, .ss_n, .mosi(sdo_drv), .cpha, .cpol,
    .miso, .rx(prx));

  // ----
  // Helpers
  // ----
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return !tx_ready;
      1: return rx_valid;
      2: return irq_done;
      3: return !busy;
      default: return evt_abort;
    endcase
  endfunction
  task automatic wait_sig(input int k);
    int n;
    n = 0;
    while (sel(k) !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  function automatic logic [31:0] rev(input logic [31:0] x, input int n);
    logic [31:0] y;
    y = 32'h0;
    for (int i = 0; i < n; i++) y[i] = x[n-1-i];
    return y;
  endfunction
  task automatic xfer(input sms_row_t r);
    int nb;
    logic [31:0] m, ed, ep;
    nb = 8 << r.w;
    m = (nb == 32) ? 32'hFFFF_FFFF : (32'h1 << nb) - 32'h1;
    ed = PAT >> (32 - nb);
    ep = r.d & m;
    if (r.lf) begin
      ed = rev(ed, nb);
      ep = rev(ep, nb);
    end
    width_sel = r.w;
    cpha = r.ph;
    cpol = r.pl;
    lsb_first = r.lf;
    @(negedge mclk);
    tx_data = r.d;
    tx_valid = 1'b1;
    start = 1'b1;
    unit_count = 16'h1;
    @(negedge mclk);
    start = 1'b0;
    wait_sig(0);
    tx_valid = 1'b0;
    wait_sig(2);
    wait_sig(1);
    chk(rx_data, ed);
    chk_bit(rx_dma_en ? dma_rx_req : irq_rx, 1'b1);
    rx_ack = 1'b1;
    @(negedge mclk);
    rx_ack = 1'b0;
    wait_sig(3);
    chk(prx & m, ep);
    chk_bit(sck, cpol);
    $display("row done width=%0d", nb);
  endtask

  always @(posedge mclk) if (irq_done === 1'b1) done_seen <= 1'b1;

  // ----
  // Sequence
  // ----
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    {arst_n, cpha, cpol, lsb_first, modf_en, tx_dma_en, rx_dma_en, done_seen} = '0;
    {start, abort, tx_valid, rx_ack, ss_force, width_sel, unit_count, tx_data} = '0;
    {power_en, master_en, err_clr, err_total, total_checks} = '0;
    power_en = 1'b1;
    master_en = 1'b1;
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    chk_bit(busy, 1'b0);
    chk_bit(sck_drv, cpol);
    $display("reset done");
    foreach (rows[i]) begin
      rx_dma_en = i[0];
      tx_dma_en = i[1];
      @(negedge mclk);
      xfer(rows[i]);
    end
    unit_count = 16'h0;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    @(negedge mclk);
    chk_bit(busy, 1'b0);
    $display("zero count done");
    unit_count = 16'h2;
    tx_valid = 1'b1;
    start = 1'b1;
    done_seen = 1'b0;
    @(negedge mclk);
    start = 1'b0;
    tx_valid = 1'b0;
    repeat (20) @(negedge mclk);
    chk_bit(tx_dma_en ? dma_tx_req : irq_tx, 1'b1);
    chk_bit(tx_dma_en ? irq_tx : dma_tx_req, 1'b0);
    abort = 1'b1;
    @(negedge mclk);
    abort = 1'b0;
    wait_sig(4);
    wait_sig(3);
    chk_bit(done_seen, 1'b0);
    $display("abort done");
    tx_valid = 1'b0;
    ss_force = 1'b1;
    repeat (8) @(negedge mclk);
    chk_bit(err_flags[0], 1'b0);
    modf_en = 1'b1;
    repeat (8) @(negedge mclk);
    chk_bit(err_flags[0], 1'b1);
    chk_bit(irq_err, 1'b1);
    ss_force = 1'b0;
    repeat (4) @(negedge mclk);
    err_clr = 6'h3F;
    @(negedge mclk);
    err_clr = 6'h00;
    @(negedge mclk);
    chk_bit(irq_err, 1'b0);
    $display("mode fault done");
    tx_valid = 1'b1;
    unit_count = 16'h4;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    repeat (10) @(negedge mclk);
    power_en = 1'b0;
    repeat (2) @(negedge mclk);
    chk_bit(busy | irq_tx | irq_rx | irq_done | irq_err | tx_ready, 1'b0);
    $display("power off done");
    report_and_stop();
  end
endmodule // test_sms_channel
